// >>> hw/psg_divider.sv
`timescale 1ns/1ps
`default_nettype none
// Restoring divider, one quotient bit per enabled clock
module psg_divider (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic start,
	input wire logic [psg_pkg::DIV_W-1:0] dividend,
	input wire logic [31:0] divisor,
	output logic done,
	output logic [psg_pkg::DIV_W-1:0] quotient,
	output logic [psg_pkg::DIV_W-1:0] remainder
);
	import psg_pkg::*;
	psg_div_type s, n;
	logic [DIV_W:0] trial;

	// ==========================================================
	// Next state
	always_comb begin
		n = s;
		n.done = 1'b0;
		trial = {s.rem, s.quo[DIV_W-1]} - {1'b0, s.dvs};
		if (start) begin
			n.busy = 1'b1;
			n.cnt = 6'(DIV_W);
			n.rem = '0;
			n.quo = dividend;
			n.dvs = {{(DIV_W-32){1'b0}}, divisor};
		end else if (s.busy) begin
			// Subtract only when it does not go negative
			if (!trial[DIV_W]) begin
				n.rem = trial[DIV_W-1:0];
				n.quo = {s.quo[DIV_W-2:0], 1'b1};
			end else begin
				n.rem = {s.rem[DIV_W-2:0], s.quo[DIV_W-1]};
				n.quo = {s.quo[DIV_W-2:0], 1'b0};
			end
			n.cnt = s.cnt - 6'h01;
			if (s.cnt == 6'h01) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s <= '0;
		end else if (clk_en) begin
			s <= n;
		end
	end

	assign done = s.done;
	assign quotient = s.quo;
	assign remainder = s.rem;
endmodule
`default_nettype wire

// >>> hw/psg_pkg.sv
package psg_pkg;
	// ==========================================================
	// Clocking and time base
	localparam int CLK_HZ = 40_000_000;
	localparam int TB_HZ = 10_000_000;
	localparam int TICK_DIV = CLK_HZ / TB_HZ;
	localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
	localparam logic [31:0] TB_HZ_W = 32'(TB_HZ);
	localparam logic [31:0] DUTY_FULL = 32'h0000_7d00;
	// ==========================================================
	// Widths
	localparam int NCH = 2;
	localparam int DIV_W = 48;
	localparam int AW = 8;
	// ==========================================================
	// Register offsets, per channel relative to channel base; the two IRQ registers are absolute
	localparam logic [7:0] OFS_DUTY = 8'h00;
	localparam logic [7:0] OFS_FREQ = 8'h04;
	localparam logic [7:0] OFS_ACC = 8'h08;
	localparam logic [7:0] OFS_RUNC = 8'h0c;
	localparam logic [7:0] OFS_DEC = 8'h10;
	localparam logic [7:0] OFS_CTRL = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] CH_STRIDE = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
	// ==========================================================
	// Field positions
	localparam int CTRL_START = 0;
	localparam int CTRL_MODE = 1;
	localparam int STAT_READY = 0;
	localparam int STAT_ERR = 1;
	localparam int STAT_PH = 2;
	localparam int STAT_OUT = 4;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_W = 2 * NCH;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_PHASE = 3'h1, S_RAMP = 3'h3, S_PER = 3'h2,
		S_WAIT = 3'h6, S_FIN = 3'h7, S_PWMP = 3'h5, S_PWMH = 3'h4
	} psg_state_type;
	typedef enum logic [1:0] {
		PH_ACC = 2'h0, PH_RUN = 2'h1, PH_DEC = 2'h3
	} psg_phase_type;
	typedef struct packed {
		logic [31:0] duty, freq, acc, runc, dec;
		logic start_bit, mode, start_prev, busy, err;
		logic [31:0] l_start, l_run, l_acc, l_runc, l_dec;
		psg_state_type st;
		psg_phase_type ph;
		logic [31:0] cnt, cur_f, dq, dr, dacc, dn;
		logic [31:0] per, hi, nper, nhi, tcnt;
		logic pend, run, out, div_go;
		logic [DIV_W-1:0] div_a;
		logic [31:0] div_b;
	} psg_chan_type;
	typedef struct packed {
		psg_chan_type [NCH-1:0] chan;
		logic [1:0] tick;
		logic tick_en;
		logic [IRQ_W-1:0] irq_st, irq_mask;
		logic irq;
		logic [31:0] rdata;
	} psg_top_type;
	typedef struct packed {
		logic busy, done;
		logic [5:0] cnt;
		logic [DIV_W-1:0] rem, quo, dvs;
	} psg_div_type;
endpackage

// >>> hw/psg_pulse_gen.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module psg_pulse_gen (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [psg_pkg::AW-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	output logic [psg_pkg::NCH-1:0] pulse_out,
	output logic irq
);
	import psg_pkg::*;
	psg_top_type s, n;
	psg_chan_type ch;
	logic [IRQ_W-1:0] ev;
	logic [NCH-1:0] dv_done;
	logic [DIV_W-1:0] dv_q [NCH];
	logic [DIV_W-1:0] dv_r [NCH];
	logic wrap, ld, bad;
	logic [31:0] pcnt, rv;

	// Byte address of a channel register
	function automatic logic [7:0] reg_addr(input int c, input logic [7:0] ofs);
		return 8'(c * int'(CH_STRIDE)) + ofs;
	endfunction

	// Step count of the given phase
	function automatic logic [31:0] phase_cnt(input psg_chan_type x);
		case (x.ph)
			PH_ACC: phase_cnt = x.l_acc;
			PH_RUN: phase_cnt = x.l_runc;
			default: phase_cnt = x.l_dec;
		endcase
	endfunction

	// Queue a period division for the current rate
	function automatic psg_chan_type per_div(input psg_chan_type x);
		per_div = x;
		per_div.div_go = 1'b1;
		per_div.div_a = DIV_W'(TB_HZ_W);
		per_div.div_b = x.cur_f;
		per_div.st = S_PER;
	endfunction

	// Move to the next phase, or finish after deceleration
	function automatic psg_chan_type next_phase(input psg_chan_type x);
		next_phase = x;
		if (x.ph == PH_DEC) begin
			next_phase.st = S_FIN;
		end else begin
			next_phase.ph = (x.ph == PH_ACC) ? PH_RUN : PH_DEC;
			next_phase.st = S_PHASE;
		end
	endfunction

	// Linear ramp step with remainder carry so the end rate is exact
	function automatic psg_chan_type ramp_step(input psg_chan_type x);
		logic [31:0] a;
		logic inc;
		ramp_step = x;
		a = x.dacc + x.dr;
		inc = (a >= x.dn);
		ramp_step.dacc = inc ? a - x.dn : a;
		if (x.ph == PH_ACC) begin
			ramp_step.cur_f = x.cur_f + x.dq + {31'h0, inc};
		end else begin
			ramp_step.cur_f = x.cur_f - x.dq - {31'h0, inc};
		end
	endfunction

	// ==========================================================
	// One divider per channel
	for (genvar g = 0; g < NCH; g++) begin : g_div
		psg_divider u_div (
			.core_clk(core_clk),
			.reset(reset),
			.clk_en(clk_en),
			.start(s.chan[g].div_go),
			.dividend(s.chan[g].div_a),
			.divisor(s.chan[g].div_b),
			.done(dv_done[g]),
			.quotient(dv_q[g]),
			.remainder(dv_r[g])
		);
	end

	// ==========================================================
	// Next state: time base, bus, channels, interrupts
	always_comb begin
		n = s;
		ev = '0;
		ch = s.chan[0];
		wrap = 1'b0;
		ld = 1'b0;
		bad = 1'b0;
		pcnt = '0;
		rv = '0;
		// Divide the core clock down to the pulse time base
		n.tick_en = (s.tick == TICK_LAST);
		n.tick = n.tick_en ? 2'h0 : s.tick + 2'h1;
		for (int c = 0; c < NCH; c++) begin
			ch = s.chan[c];
			ch.div_go = 1'b0;
			// Software writes to settings
			if (bus_wr) begin
				case (bus_addr)
					reg_addr(c, OFS_DUTY): ch.duty = bus_wdata;
					reg_addr(c, OFS_FREQ): ch.freq = bus_wdata;
					reg_addr(c, OFS_ACC): ch.acc = bus_wdata;
					reg_addr(c, OFS_RUNC): ch.runc = bus_wdata;
					reg_addr(c, OFS_DEC): ch.dec = bus_wdata;
					reg_addr(c, OFS_CTRL): begin
						ch.start_bit = bus_wdata[CTRL_START];
						ch.mode = bus_wdata[CTRL_MODE];
					end
					default: ;
				endcase
			end
			// Period counter counts whole time-base ticks only
			wrap = ch.run && s.tick_en && (ch.tcnt == ch.per - 32'h1);
			ld = ch.pend && s.tick_en && (!ch.run || wrap);
			if (ld) begin
				ch.per = ch.nper;
				ch.hi = ch.nhi;
				ch.tcnt = '0;
				ch.run = 1'b1;
				ch.pend = !ch.mode;
			end else if (wrap) begin
				ch.run = 1'b0;
			end else if (ch.run && s.tick_en) begin
				ch.tcnt = ch.tcnt + 32'h1;
			end
			// Control sequence
			case (ch.st)
				S_IDLE: begin
					// A stepper at rest drives nothing; PWM keeps its reload queued
					if (ch.mode) begin
						ch.run = 1'b0;
						ch.pend = 1'b0;
					end
					if (!ch.mode && ch.freq != 32'h0) begin
						ch.div_go = 1'b1;
						ch.div_a = DIV_W'(TB_HZ_W);
						ch.div_b = ch.freq;
						ch.st = S_PWMP;
					end else if (ch.mode && ch.start_bit && !ch.start_prev && !ch.busy) begin
						ch.l_start = ch.duty;
						ch.l_run = ch.freq;
						ch.l_acc = ch.acc;
						ch.l_runc = ch.runc;
						ch.l_dec = ch.dec;
						bad = (ch.acc == 32'h1) || (ch.dec == 32'h1);
						bad = bad || (ch.freq == 32'h0);
						if (ch.acc != 32'h0 || ch.dec != 32'h0) begin
							bad = bad || (ch.duty == 32'h0) || (ch.duty > ch.freq);
						end
						ch.err = bad;
						if (bad) begin
							ev[c * 2 + IRQ_ERR] = 1'b1;
						end else begin
							ch.busy = 1'b1;
							ch.ph = PH_ACC;
							ch.st = S_PHASE;
						end
					end
				end
				S_PHASE: begin
					pcnt = phase_cnt(ch);
					if (pcnt == 32'h0) begin
						ch = next_phase(ch);
					end else begin
						ch.cnt = pcnt;
						// First pulse of a phase: start rate rising, run rate otherwise
						ch.cur_f = (ch.ph == PH_ACC) ? ch.l_start : ch.l_run;
						if (ch.ph == PH_RUN) begin
							ch.dq = '0;
							ch.dr = '0;
							ch = per_div(ch);
						end else begin
							ch.div_go = 1'b1;
							ch.div_a = DIV_W'(ch.l_run - ch.l_start);
							ch.div_b = pcnt - 32'h1;
							ch.dn = pcnt - 32'h1;
							ch.st = S_RAMP;
						end
					end
				end
				S_RAMP: begin
					if (dv_done[c]) begin
						ch.dq = dv_q[c][31:0];
						ch.dr = dv_r[c][31:0];
						ch.dacc = '0;
						ch = per_div(ch);
					end
				end
				S_PER: begin
					if (dv_done[c]) begin
						ch.nper = dv_q[c][31:0];
						ch.nhi = dv_q[c][31:0] - {1'b0, dv_q[c][31:1]};
						ch.pend = 1'b1;
						// Run phase holds its rate; only the ramps step it
						if (ch.ph != PH_RUN) begin
							ch = ramp_step(ch);
						end
						ch.st = S_WAIT;
					end
				end
				S_WAIT: begin
					if (ld) begin
						ch.cnt = ch.cnt - 32'h1;
						if (ch.cnt == 32'h0) begin
							ch = next_phase(ch);
						end else begin
							ch = per_div(ch);
						end
					end
				end
				S_FIN: begin
					// Ready only once the last pulse has fully played out
					if (!ch.run && !ch.pend) begin
						ch.busy = 1'b0;
						ch.st = S_IDLE;
						ev[c * 2 + IRQ_DONE] = 1'b1;
					end
				end
				S_PWMP: begin
					if (ch.mode) begin
						ch.st = S_IDLE;
						ch.run = 1'b0;
					end else if (dv_done[c]) begin
						ch.nper = dv_q[c][31:0];
						ch.div_go = 1'b1;
						ch.div_a = DIV_W'(dv_q[c][31:0]) * DIV_W'(ch.duty);
						ch.div_b = DUTY_FULL;
						ch.st = S_PWMH;
					end
				end
				S_PWMH: begin
					if (ch.mode) begin
						ch.st = S_IDLE;
						ch.run = 1'b0;
					end else if (dv_done[c]) begin
						ch.nhi = dv_q[c][31:0];
						ch.pend = 1'b1;
						ch.st = S_IDLE;
					end
				end
				default: ch.st = S_IDLE;
			endcase
			// Dropping start mid-move aborts; the pulse is cut at once
			if (ch.busy && !ch.start_bit) begin
				ch.busy = 1'b0;
				ch.err = 1'b1;
				ch.run = 1'b0;
				ch.pend = 1'b0;
				ch.st = S_IDLE;
				ev[c * 2 + IRQ_ERR] = 1'b1;
			end
			// Track start only at rest, so a start written mid-division is not lost
			if (s.chan[c].st == S_IDLE) begin
				ch.start_prev = ch.start_bit;
			end
			// Output select; PWM settings bypass the counter at the ends
			if (ch.mode) begin
				ch.out = ch.run && (ch.tcnt < ch.hi);
			end else if (ch.duty == 32'h0 || ch.freq == 32'h0) begin
				ch.out = 1'b0;
			end else if (ch.duty >= DUTY_FULL) begin
				ch.out = 1'b1;
			end else begin
				ch.out = ch.run && (ch.tcnt < ch.hi);
			end
			n.chan[c] = ch;
		end
		// Sticky status, write one to clear; a new event wins
		if (bus_wr && bus_addr == OFS_IRQ_STAT) begin
			n.irq_st = s.irq_st & ~bus_wdata[IRQ_W-1:0];
		end
		if (bus_wr && bus_addr == OFS_IRQ_MASK) begin
			n.irq_mask = bus_wdata[IRQ_W-1:0];
		end
		n.irq_st = n.irq_st | ev;
		n.irq = |(n.irq_st & n.irq_mask);
		// Read data valid only in the cycle after the strobe
		if (bus_rd) begin
			for (int c = 0; c < NCH; c++) begin
				case (bus_addr)
					reg_addr(c, OFS_DUTY): rv = s.chan[c].duty;
					reg_addr(c, OFS_FREQ): rv = s.chan[c].freq;
					reg_addr(c, OFS_ACC): rv = s.chan[c].acc;
					reg_addr(c, OFS_RUNC): rv = s.chan[c].runc;
					reg_addr(c, OFS_DEC): rv = s.chan[c].dec;
					reg_addr(c, OFS_CTRL): begin
						rv[CTRL_START] = s.chan[c].start_bit;
						rv[CTRL_MODE] = s.chan[c].mode;
					end
					reg_addr(c, OFS_STAT): begin
						rv[STAT_READY] = !s.chan[c].busy;
						rv[STAT_ERR] = s.chan[c].err;
						rv[STAT_PH +: 2] = s.chan[c].ph;
						rv[STAT_OUT] = s.chan[c].out;
					end
					default: ;
				endcase
			end
			if (bus_addr == OFS_IRQ_STAT) begin
				rv[IRQ_W-1:0] = s.irq_st;
			end
			if (bus_addr == OFS_IRQ_MASK) begin
				rv[IRQ_W-1:0] = s.irq_mask;
			end
		end
		n.rdata = rv;
	end

	// ==========================================================
	// State register; clock enable low freezes everything
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s <= '0;
		end else if (clk_en) begin
			s <= n;
		end
	end

	// ==========================================================
	// Outputs straight from state flops
	assign bus_rdata = s.rdata;
	assign irq = s.irq;
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			pulse_out[c] = s.chan[c].out;
		end
	end
endmodule
`default_nettype wire

// >>> test/psg_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks: channel zero pulse output, plus read data and interrupt
module psg_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [psg_pkg::AW-1:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic [psg_pkg::NCH-1:0] pulse_out,
	input wire logic irq
);
	import psg_pkg::*;
	logic [31:0] dty_reg, frq_reg;
	logic [19:0] per_reg, hi_reg;
	logic [3:0] msk_reg;
	logic md_reg, prv_reg, cln_reg, rise;
	assign rise = pulse_out[0] && !prv_reg;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Shadows of written settings; any write spoils the next period measure
	always_ff @(posedge core_clk) begin
		prv_reg <= pulse_out[0];
		per_reg <= rise ? 20'h1 : per_reg + 20'h1;
		hi_reg <= rise ? 20'h1 : hi_reg + 20'(pulse_out[0]);
		if (reset) begin
			dty_reg <= 32'h0;
			frq_reg <= 32'h0;
			md_reg <= 1'b0;
			msk_reg <= 4'h0;
			cln_reg <= 1'b0;
		end else if (clk_en) begin
			cln_reg <= bus_wr ? 1'b0 : (rise | cln_reg);
			if (bus_wr && bus_addr == OFS_DUTY) dty_reg <= bus_wdata;
			if (bus_wr && bus_addr == OFS_FREQ) frq_reg <= bus_wdata;
			if (bus_wr && bus_addr == OFS_CTRL) md_reg <= bus_wdata[CTRL_MODE];
			if (bus_wr && bus_addr == OFS_IRQ_MASK) msk_reg <= bus_wdata[3:0];
		end
	end
	full_duty_a: assert property (
		!md_reg && $stable(md_reg) && frq_reg != 32'h0 && dty_reg == DUTY_FULL
		&& $stable(dty_reg) |-> pulse_out[0]) else $error("full duty not high");
	zero_duty_a: assert property (
		!md_reg && $stable(md_reg) && dty_reg == 32'h0 && $stable(dty_reg)
		|-> !pulse_out[0]) else $error("zero duty not low");
	no_freq_a: assert property (
		!md_reg && $stable(md_reg) && frq_reg == 32'h0 && dty_reg != DUTY_FULL
		&& $stable(dty_reg) && $stable(frq_reg) |-> !pulse_out[0]) else $error("no freq not low");
	abort_low_a: assert property (
		bus_wr && bus_addr == OFS_CTRL && bus_wdata[1:0] == 2'b10
		|-> ##2 !pulse_out[0] [*3]) else $error("abort left output high");
	period_ticks_a: assert property (
		rise && cln_reg |-> per_reg[1:0] == 2'b00) else $error("period off tick");
	high_ticks_a: assert property (
		$fell(pulse_out[0]) && cln_reg |-> hi_reg[1:0] == 2'b00) else $error("high off tick");
	rdata_idle_a: assert property (
		clk_en && !bus_rd |=> bus_rdata == 32'h0) else $error("read data not idle");
	irq_masked_a: assert property (
		msk_reg == 4'h0 && $stable(msk_reg) |-> !irq) else $error("masked irq high");
	cover property (rise && cln_reg);
	cover property ($rose(irq));
	cover property (bus_wr && bus_addr == OFS_CTRL && bus_wdata[1:0] == 2'b10 && pulse_out[0]);
endmodule
`default_nettype wire

// >>> test/psg_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Drive step input: counts steps, times period and high time
module psg_drive_model (
	input wire logic core_clk,
	input wire logic clr,
	input wire logic step_in,
	output logic [31:0] steps,
	output logic [31:0] first_per,
	output logic [31:0] min_per,
	output logic [31:0] last_per,
	output logic [31:0] last_hi
);
	logic prv_reg;
	logic [31:0] t_reg, h_reg;
	// A drive only listens, so it cannot stall or reshape pulses
	always_ff @(posedge core_clk) begin
		prv_reg <= step_in;
		t_reg <= (step_in && !prv_reg) ? 32'h1 : t_reg + 32'h1;
		h_reg <= (step_in && !prv_reg) ? 32'h1 : h_reg + 32'(step_in);
		if (!step_in && prv_reg) last_hi <= h_reg;
		if (clr) begin
			steps <= 32'h0;
			min_per <= 32'hffff_ffff;
		end else if (step_in && !prv_reg) begin
			steps <= steps + 32'h1;
			if (steps != 32'h0) last_per <= t_reg;
			if (steps == 32'h1) first_per <= t_reg;
			if (steps != 32'h0 && t_reg < min_per) min_per <= t_reg;
		end
	end
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Self-checking bench for the pulse generator
module testbench;
	import psg_pkg::*;
	typedef struct packed {logic [31:0] f; logic [31:0] d; logic [31:0] p; logic [31:0] h;} psg_row_type;
	// Frequency, duty, then period and high time in clocks
	psg_row_type rows [3] = '{'{32'h4e20, 32'h3e80, 32'h7d0, 32'h3e8},
		'{32'h186a0, 32'h1f40, 32'h190, 32'h64}, '{32'h7530, 32'h7080, 32'h534, 32'h4ac}};
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [AW-1:0] bus_addr = '0;
	logic [31:0] bus_wdata = '0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic clr = 1'b1;
	logic [31:0] bus_rdata;
	logic [NCH-1:0] pulse_out;
	logic irq;
	logic [31:0] step_pulse_function [2], fp [2], mp [2], lp [2], lh [2];
	int failures = 0;
	int cmp_count = 0;
	always #12.5 core_clk = ~core_clk;
	psg_pulse_gen dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.pulse_out(pulse_out), .irq(irq));
	for (genvar i = 0; i < 2; i++) begin : g_m
		psg_drive_model m (.core_clk(core_clk), .clr(clr), .step_in(pulse_out[i]), .steps(step_pulse_function[i]),
			.first_per(fp[i]), .min_per(mp[i]), .last_per(lp[i]), .last_hi(lh[i]));
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1 chk(n, e, bus_rdata & m);
	endtask
	task automatic clear();
		@(posedge core_clk);
		clr <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge core_clk);
		chk("irq", 32'h1, 32'(irq));
	endtask
	task automatic final_report();
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog, well past the longest expected run
	initial begin
		repeat (95000) @(posedge core_clk);
		failures++;
		final_report();
	end
	// Main sequence
	initial begin
		logic [31:0] n;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		clr <= 1'b0;
		rd(OFS_STAT, 32'h1f, 32'h1, "stat");
		rd(8'h80, 32'hffff_ffff, 32'h0, "unmapped");
		wr(OFS_STAT, 32'h2);
		rd(OFS_STAT, 32'h3, 32'h1, "stat ro");
		wr(OFS_DUTY, 32'h3e80);
		repeat (600) @(posedge core_clk);
		chk("no freq", 32'h0, 32'(pulse_out[0]));
		foreach (rows[i]) begin
			wr(OFS_FREQ, rows[i].f);
			wr(OFS_DUTY, rows[i].d);
			repeat (2 * rows[i].p + 300) @(posedge core_clk);
			clear();
			for (int k = 0; k < 4 * rows[i].p && step_pulse_function[0] < 3; k++) @(posedge core_clk);
			chk("period", rows[i].p, lp[0]);
			chk("high", rows[i].h, lh[0]);
		end
		// Full and zero duty with a frequency that gives no useful period
		wr(OFS_FREQ, 32'h7);
		wr(OFS_DUTY, DUTY_FULL);
		repeat (3000) @(posedge core_clk);
		chk("full", 32'h1, 32'(pulse_out[0]));
		wr(OFS_DUTY, 32'h0);
		repeat (3000) @(posedge core_clk);
		chk("zero", 32'h0, 32'(pulse_out[0]));
		// Ramped move; the run rate change after start must not reach it
		wr(OFS_IRQ_MASK, 32'h7);
		wr(OFS_DUTY, 32'h186a0);
		wr(OFS_FREQ, 32'h30d40);
		wr(OFS_ACC, 32'h4);
		wr(OFS_RUNC, 32'h3);
		wr(OFS_DEC, 32'h4);
		clear();
		wr(OFS_CTRL, 32'h3);
		wr(OFS_FREQ, 32'h61a80);
		rd(OFS_STAT, 32'h1, 32'h0, "busy");
		wait_irq();
		rd(OFS_STAT, 32'h3, 32'h1, "ready");
		chk("steps", 32'hb, step_pulse_function[0]);
		chk("first", 32'h190, fp[0]);
		chk("min", 32'hc8, mp[0]);
		chk("last", 32'h128, lp[0]);
		wr(OFS_IRQ_STAT, 32'h1);
		rd(OFS_IRQ_STAT, 32'hf, 32'h0, "w1c");
		// Ramp count of one is refused with an error
		wr(OFS_ACC, 32'h1);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h3);
		repeat (3) @(posedge core_clk);
		rd(OFS_STAT, 32'h3, 32'h3, "acc one");
		rd(OFS_IRQ_STAT, 32'hf, 32'h2, "err irq");
		chk("irq err", 32'h1, 32'(irq));
		wr(OFS_IRQ_STAT, 32'h2);
		// Second channel, zero ramp counts skip both ramps
		wr(CH_STRIDE + OFS_FREQ, 32'h30d40);
		wr(CH_STRIDE + OFS_RUNC, 32'h2);
		clear();
		wr(CH_STRIDE + OFS_CTRL, 32'h3);
		wait_irq();
		chk("steps1", 32'h2, step_pulse_function[1]);
		chk("first1", 32'hc8, fp[1]);
		wr(OFS_IRQ_STAT, 32'h4);
		// Start bit dropped mid-move
		wr(OFS_ACC, 32'h0);
		wr(OFS_FREQ, 32'h30d40);
		wr(OFS_RUNC, 32'h3e8);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h3);
		repeat (2000) @(posedge core_clk);
		// Clock enable low must freeze the move
		n = step_pulse_function[0];
		clk_en <= 1'b0;
		repeat (400) @(posedge core_clk);
		chk("frozen", n, step_pulse_function[0]);
		clk_en <= 1'b1;
		wr(OFS_CTRL, 32'h2);
		rd(OFS_STAT, 32'h3, 32'h3, "abort");
		n = step_pulse_function[0];
		repeat (1000) @(posedge core_clk);
		chk("stopped", n, step_pulse_function[0]);
		chk("abort out", 32'h0, 32'(pulse_out[0]));
		final_report();
	end
endmodule
bind psg_pulse_gen psg_checker chk_i (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .pulse_out(pulse_out), .irq(irq));
`default_nettype wire
